// [verilog/fcs_consts.svh]
// constants for the flash command sequencer host
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH
// register offsets (byte addresses)
`define FCS_REG_CTRL 8'h00
`define FCS_REG_ADDR 8'h04
`define FCS_REG_WDATA 8'h08
`define FCS_REG_RDATA 8'h0c
`define FCS_REG_STAT 8'h10
`define FCS_REG_IRQ 8'h14
`define FCS_REG_MASK 8'h18
// ctrl fields
`define FCS_CTRL_OP_LSB 0
`define FCS_CTRL_WORD_BIT 4
`define FCS_CTRL_UNLOCK_BIT 5
// irq bits
`define FCS_IRQ_DONE 0
`define FCS_IRQ_ERR 1
// command codes
`define FCS_CMD_RESET 8'hf0
`define FCS_CMD_IDENT 8'h90
`define FCS_CMD_PROG 8'ha0
`define FCS_UNLOCK1_DATA 8'haa
`define FCS_UNLOCK2_DATA 8'h55
// unlock addresses
`define FCS_ADDR1_BYTE 20'h0aaaa
`define FCS_ADDR1_WORD 20'h05555
`define FCS_ADDR2_BYTE 20'h05555
`define FCS_ADDR2_WORD 20'h02aaa
// status bit positions
`define FCS_POLL_BIT 7
`define FCS_TOGGLE_BIT 6
`define FCS_ERR_BIT 5
// timing
`define FCS_CLK_MHZ 10
`define FCS_ERASE_WAIT_US 10
`define FCS_ERASE_WAIT_CYC (`FCS_ERASE_WAIT_US * `FCS_CLK_MHZ)
`define FCS_STROBE_CYC 2
`endif

// [verilog/fcs_pkg.sv]
// types for the flash command sequencer host
package fcs_pkg;
  typedef enum logic [1:0] {
    fcs_op_reset,
    fcs_op_ident,
    fcs_op_prog,
    fcs_op_read
  } fcs_op_t;
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [19:0] addr;
    logic [15:0] dq_out;
    logic dq_oe;
  } fcs_pins_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [19:0] addr;
    logic [15:0] data;
  } fcs_cyc_t;
endpackage

// [verilog/fcs_cycle.sv]
// one asynchronous bus cycle on the flash pins
`timescale 1ns/1ps
`include "fcs_consts.svh"
module fcs_cycle (
  input wire logic core_clk,
  input wire logic rst,
  input wire fcs_pkg::fcs_cyc_t req,
  input wire logic [15:0] dq_in,
  output fcs_pkg::fcs_pins_t pins,
  output logic done,
  output logic [15:0] rdata
);
  typedef enum logic [1:0] {cy_idle, cy_setup, cy_strobe, cy_hold} fcs_cy_t;
  fcs_cy_t st_ff, nxt_st;
  logic [2:0] cnt_ff, nxt_cnt; // wide enough for the five-cycle strobe
  fcs_pkg::fcs_pins_t pins_ff, nxt_pins;
  logic done_ff, nxt_done;
  logic [15:0] rd_ff, nxt_rd;
  logic [15:0] s1_ff, s2_ff, s3_ff;

  // ===========================================
  // data pins cross in: three flops, accept when last two agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_ff <= 16'h0000;
      s2_ff <= 16'h0000;
      s3_ff <= 16'h0000;
    end else begin
      s1_ff <= dq_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // ===========================================
  // strobe sequencer: address first, then ce/we or ce/oe low, then release
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_pins = pins_ff;
    nxt_done = 1'b0;
    nxt_rd = rd_ff;
    unique case (st_ff)
      cy_idle: begin
        if (req.wr || req.rd) begin
          nxt_pins.addr = req.addr;
          nxt_pins.dq_out = req.data;
          nxt_pins.dq_oe = req.wr;
          nxt_st = cy_setup;
        end
      end
      cy_setup: begin
        nxt_pins.ce_n = 1'b0;
        nxt_pins.we_n = pins_ff.dq_oe ? 1'b0 : 1'b1; // address taken at the later falling edge
        nxt_pins.oe_n = pins_ff.dq_oe ? 1'b1 : 1'b0;
        nxt_cnt = 3'(`FCS_STROBE_CYC + 2); // room for the read sync delay
        nxt_st = cy_strobe;
      end
      cy_strobe: begin
        if (cnt_ff == 3'h0) begin
          // data latched by the device on this rising edge
          nxt_pins.ce_n = 1'b1;
          nxt_pins.we_n = 1'b1;
          nxt_pins.oe_n = 1'b1;
          if (s2_ff == s3_ff) begin
            nxt_rd = s3_ff;
          end
          nxt_st = cy_hold;
        end else begin
          nxt_cnt = cnt_ff - 3'h1;
        end
      end
      cy_hold: begin
        nxt_pins.dq_oe = 1'b0; // data held one cycle past the strobe
        nxt_done = 1'b1;
        nxt_st = cy_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= cy_idle;
      cnt_ff <= 3'h0;
      pins_ff <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 20'h00000,
                   dq_out: 16'h0000, dq_oe: 1'b0};
      done_ff <= 1'b0;
      rd_ff <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      pins_ff <= nxt_pins;
      done_ff <= nxt_done;
      rd_ff <= nxt_rd;
    end
  end

  assign pins = pins_ff;
  assign done = done_ff;
  assign rdata = rd_ff;

  // ===========================================
  // checks
  strobe_excl_a: assert property (@(posedge core_clk) disable iff (rst)
    !(pins_ff.we_n == 1'b0 && pins_ff.oe_n == 1'b0))
    else $error("write and output strobes low together");
  drive_write_a: assert property (@(posedge core_clk) disable iff (rst)
    (pins_ff.we_n == 1'b0) |-> pins_ff.dq_oe)
    else $error("write strobe without driven data");
endmodule

// [verilog/fcs_host.sv]
// host controller issuing reset, identify, program and read to the flash
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "fcs_consts.svh"
module fcs_host (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [19:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in
);
  typedef enum logic [2:0] {
    sq_idle, sq_unl1, sq_unl2, sq_cmd, sq_data, sq_poll, sq_wait
  } fcs_sq_t;

  fcs_sq_t sq_ff, nxt_sq;
  fcs_pkg::fcs_cyc_t cyc_ff, nxt_cyc;
  logic [5:0] ctrl_ff, nxt_ctrl;
  logic [19:0] addr_ff, nxt_addr;
  logic [15:0] wd_ff, nxt_wd;
  logic [15:0] rd_ff, nxt_rd;
  logic [15:0] prev_ff, nxt_prev;
  logic busy_ff, nxt_busy;
  logic [1:0] irqs_ff, nxt_irqs;
  logic [1:0] mask_ff, nxt_mask;
  logic [9:0] wcnt_ff, nxt_wcnt;
  logic go_ff, nxt_go;
  logic awt_ff, nxt_awt, wt_ff, nxt_wt;
  logic [7:0] awa_ff, nxt_awa;
  logic [31:0] wdl_ff, nxt_wdl;
  logic bv_ff, nxt_bv, rv_ff, nxt_rv;
  logic [31:0] rdat_ff, nxt_rdat;
  logic [1:0] rresp_ff, nxt_rresp, bresp_ff, nxt_bresp;
  logic irq_ff;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  fcs_pkg::fcs_pins_t pins;
  logic [1:0] ev_set;

  fcs_cycle fcs_cycle_i (
    .core_clk(core_clk),
    .rst(rst),
    .req(cyc_ff),
    .dq_in(flash_dq_in),
    .pins(pins),
    .done(cyc_done),
    .rdata(cyc_rdata)
  );

  // unlock and command addresses depend on bus width
  function automatic logic [19:0] unl_addr(input logic word, input logic second);
    if (second) begin
      unl_addr = word ? `FCS_ADDR2_WORD : `FCS_ADDR2_BYTE;
    end else begin
      unl_addr = word ? `FCS_ADDR1_WORD : `FCS_ADDR1_BYTE;
    end
  endfunction

  function automatic fcs_pkg::fcs_cyc_t wr_cyc(input logic [19:0] a, input logic [15:0] d);
    wr_cyc = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
  endfunction

  // ===========================================
  // command sequencer
  always_comb begin
    nxt_sq = sq_ff;
    nxt_cyc = '{wr: 1'b0, rd: 1'b0, addr: 20'h00000, data: 16'h0000};
    nxt_rd = rd_ff;
    nxt_prev = prev_ff;
    nxt_busy = busy_ff;
    nxt_wcnt = wcnt_ff;
    ev_set = 2'b00;
    unique case (sq_ff)
      sq_idle: begin
        if (go_ff) begin
          nxt_busy = 1'b1;
          if (ctrl_ff[1:0] == 2'(fcs_pkg::fcs_op_read)) begin
            nxt_cyc = '{wr: 1'b0, rd: 1'b1, addr: addr_ff, data: 16'h0000};
            nxt_sq = sq_data;
          end else if (ctrl_ff[1:0] != 2'(fcs_pkg::fcs_op_reset) || ctrl_ff[5]) begin
            nxt_cyc = wr_cyc(unl_addr(ctrl_ff[4], 1'b0), 16'(`FCS_UNLOCK1_DATA));
            nxt_sq = sq_unl1;
          end else begin
            nxt_cyc = wr_cyc(addr_ff, 16'(`FCS_CMD_RESET));
            nxt_sq = sq_cmd;
          end
        end
      end
      sq_unl1: if (cyc_done) begin
        nxt_cyc = wr_cyc(unl_addr(ctrl_ff[4], 1'b1), 16'(`FCS_UNLOCK2_DATA));
        nxt_sq = sq_unl2;
      end
      sq_unl2: if (cyc_done) begin
        unique case (ctrl_ff[1:0])
          2'(fcs_pkg::fcs_op_ident): nxt_cyc = wr_cyc(unl_addr(ctrl_ff[4], 1'b0),
                                                     16'(`FCS_CMD_IDENT));
          2'(fcs_pkg::fcs_op_prog): nxt_cyc = wr_cyc(unl_addr(ctrl_ff[4], 1'b0),
                                                    16'(`FCS_CMD_PROG));
          default: nxt_cyc = wr_cyc(addr_ff, 16'(`FCS_CMD_RESET));
        endcase
        nxt_sq = sq_cmd;
      end
      sq_cmd: if (cyc_done) begin
        if (ctrl_ff[1:0] == 2'(fcs_pkg::fcs_op_prog)) begin
          nxt_cyc = wr_cyc(addr_ff, wd_ff);
          nxt_sq = sq_data;
        end else begin
          nxt_wcnt = 10'(`FCS_ERASE_WAIT_CYC); // settle before trusting reads
          nxt_sq = sq_wait;
        end
      end
      sq_data: if (cyc_done) begin
        if (cyc_ff.rd || ctrl_ff[1:0] != 2'(fcs_pkg::fcs_op_prog)) begin
          nxt_rd = cyc_rdata;
          nxt_busy = 1'b0;
          ev_set[`FCS_IRQ_DONE] = 1'b1;
          nxt_sq = sq_idle;
        end else begin
          nxt_prev = 16'h0000;
          nxt_cyc = '{wr: 1'b0, rd: 1'b1, addr: addr_ff, data: 16'h0000};
          nxt_sq = sq_poll;
        end
      end
      sq_poll: if (cyc_done) begin
        nxt_rd = cyc_rdata;
        nxt_prev = cyc_rdata;
        // toggle flag still moving means the program is still running
        if (prev_ff != 16'h0000 && cyc_rdata[`FCS_TOGGLE_BIT] == prev_ff[`FCS_TOGGLE_BIT]) begin
          nxt_busy = 1'b0;
          ev_set[`FCS_IRQ_DONE] = 1'b1;
          nxt_sq = sq_idle;
        end else if (cyc_rdata[`FCS_ERR_BIT] && prev_ff != 16'h0000) begin
          nxt_busy = 1'b0; // failure: software then issues reset to clear it
          ev_set[`FCS_IRQ_ERR] = 1'b1;
          nxt_sq = sq_idle;
        end else begin
          nxt_prev = cyc_rdata | 16'h8000; // nonzero marks a first sample taken
          nxt_cyc = '{wr: 1'b0, rd: 1'b1, addr: addr_ff, data: 16'h0000};
        end
      end
      sq_wait: begin
        if (wcnt_ff == 10'h000) begin
          nxt_busy = 1'b0;
          ev_set[`FCS_IRQ_DONE] = 1'b1;
          nxt_sq = sq_idle;
        end else begin
          nxt_wcnt = wcnt_ff - 10'h001;
        end
      end
      default: nxt_sq = sq_idle;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sq_ff <= sq_idle;
      cyc_ff <= '{wr: 1'b0, rd: 1'b0, addr: 20'h00000, data: 16'h0000};
      rd_ff <= 16'h0000;
      prev_ff <= 16'h0000;
      busy_ff <= 1'b0;
      wcnt_ff <= 10'h000;
    end else begin
      sq_ff <= nxt_sq;
      cyc_ff <= nxt_cyc;
      rd_ff <= nxt_rd;
      prev_ff <= nxt_prev;
      busy_ff <= nxt_busy;
      wcnt_ff <= nxt_wcnt;
    end
  end

  // ===========================================
  // axi4-lite slave: registers, sticky irq, mask
  logic wr_fire, rd_fire;
  assign wr_fire = awt_ff && wt_ff && !bv_ff;
  assign rd_fire = arvalid && !rv_ff;

  always_comb begin
    nxt_awt = awt_ff || awvalid;
    nxt_awa = (awvalid && !awt_ff) ? awaddr : awa_ff;
    nxt_wt = wt_ff || wvalid;
    nxt_wdl = (wvalid && !wt_ff) ? wdata : wdl_ff;
    nxt_bv = bv_ff && !bready;
    nxt_bresp = bresp_ff;
    nxt_ctrl = ctrl_ff;
    nxt_addr = addr_ff;
    nxt_wd = wd_ff;
    nxt_mask = mask_ff;
    nxt_go = 1'b0;
    nxt_irqs = irqs_ff;
    if (wr_fire) begin
      nxt_awt = 1'b0;
      nxt_wt = 1'b0;
      nxt_bv = 1'b1;
      nxt_bresp = 2'h0;
      unique case (awa_ff)
        `FCS_REG_CTRL: if (!busy_ff) begin
          nxt_ctrl = wdl_ff[5:0];
          nxt_go = 1'b1;
        end
        `FCS_REG_ADDR: nxt_addr = wdl_ff[19:0];
        `FCS_REG_WDATA: nxt_wd = wdl_ff[15:0];
        `FCS_REG_IRQ: nxt_irqs = irqs_ff & ~wdl_ff[1:0];
        `FCS_REG_MASK: nxt_mask = wdl_ff[1:0];
        `FCS_REG_RDATA, `FCS_REG_STAT: ;
        default: nxt_bresp = 2'h2;
      endcase
    end
    nxt_irqs = nxt_irqs | ev_set; // a set in the clear cycle wins
    nxt_rv = rv_ff && !rready;
    nxt_rdat = rdat_ff;
    nxt_rresp = rresp_ff;
    if (rd_fire) begin
      nxt_rv = 1'b1;
      nxt_rresp = 2'h0;
      unique case (araddr)
        `FCS_REG_CTRL: nxt_rdat = {26'h0000000, ctrl_ff};
        `FCS_REG_ADDR: nxt_rdat = {12'h000, addr_ff};
        `FCS_REG_WDATA: nxt_rdat = {16'h0000, wd_ff};
        `FCS_REG_RDATA: nxt_rdat = {16'h0000, rd_ff};
        `FCS_REG_STAT: nxt_rdat = {29'h00000000, sq_ff == sq_wait, irqs_ff[1], busy_ff};
        `FCS_REG_IRQ: nxt_rdat = {30'h00000000, irqs_ff};
        `FCS_REG_MASK: nxt_rdat = {30'h00000000, mask_ff};
        default: begin
          nxt_rdat = 32'h00000000;
          nxt_rresp = 2'h2;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awt_ff <= 1'b0; awa_ff <= 8'h00; wt_ff <= 1'b0; wdl_ff <= 32'h00000000;
      bv_ff <= 1'b0; bresp_ff <= 2'h0; rv_ff <= 1'b0; rdat_ff <= 32'h00000000;
      rresp_ff <= 2'h0; ctrl_ff <= 6'h00; addr_ff <= 20'h00000; wd_ff <= 16'h0000;
      mask_ff <= 2'h0; irqs_ff <= 2'h0; go_ff <= 1'b0; irq_ff <= 1'b0;
    end else begin
      awt_ff <= nxt_awt; awa_ff <= nxt_awa; wt_ff <= nxt_wt; wdl_ff <= nxt_wdl;
      bv_ff <= nxt_bv; bresp_ff <= nxt_bresp; rv_ff <= nxt_rv; rdat_ff <= nxt_rdat;
      rresp_ff <= nxt_rresp; ctrl_ff <= nxt_ctrl; addr_ff <= nxt_addr; wd_ff <= nxt_wd;
      mask_ff <= nxt_mask; irqs_ff <= nxt_irqs; go_ff <= nxt_go;
      irq_ff <= |(nxt_irqs & nxt_mask);
    end
  end

  // ===========================================
  // outputs
  assign awready = !awt_ff;
  assign wready = !wt_ff;
  assign bvalid = bv_ff;
  assign bresp = bresp_ff;
  assign arready = !rv_ff;
  assign rvalid = rv_ff;
  assign rdata = rdat_ff;
  assign rresp = rresp_ff;
  assign irq = irq_ff;
  assign flash_ce_n = pins.ce_n;
  assign flash_we_n = pins.we_n;
  assign flash_oe_n = pins.oe_n;
  assign flash_addr = pins.addr;
  assign flash_dq_out = pins.dq_out;
  assign flash_dq_oe = pins.dq_oe;

  // ===========================================
  // checks
  // irq level expected one edge later unless a register write intervened
  logic irq_exp;
  assign irq_exp = |(irqs_ff & mask_ff) || |(ev_set & mask_ff);
  reset_cmd_a: assert property (@(posedge core_clk) disable iff (rst)
    (sq_ff == sq_cmd && cyc_ff.wr && ctrl_ff[1:0] == 2'(fcs_pkg::fcs_op_reset))
    |-> cyc_ff.data == 16'(`FCS_CMD_RESET))
    else $error("reset command value wrong");
  unlock_one_a: assert property (@(posedge core_clk) disable iff (rst)
    (sq_ff == sq_unl1 && cyc_ff.wr) |-> cyc_ff.data == 16'(`FCS_UNLOCK1_DATA))
    else $error("first unlock data wrong");
  unlock_two_a: assert property (@(posedge core_clk) disable iff (rst)
    (sq_ff == sq_unl2 && cyc_ff.wr) |-> cyc_ff.addr == unl_addr(ctrl_ff[4], 1'b1))
    else $error("second unlock address wrong");
  ident_cmd_a: assert property (@(posedge core_clk) disable iff (rst)
    (sq_ff == sq_cmd && cyc_ff.wr && ctrl_ff[1:0] == 2'(fcs_pkg::fcs_op_ident))
    |-> cyc_ff.data == 16'(`FCS_CMD_IDENT))
    else $error("identify command wrong");
  prog_cmd_a: assert property (@(posedge core_clk) disable iff (rst)
    (sq_ff == sq_cmd && cyc_ff.wr && ctrl_ff[1:0] == 2'(fcs_pkg::fcs_op_prog))
    |-> cyc_ff.data == 16'(`FCS_CMD_PROG))
    else $error("program command wrong");
  prog_data_a: assert property (@(posedge core_clk) disable iff (rst)
    (sq_ff == sq_cmd && cyc_done && ctrl_ff[1:0] == 2'(fcs_pkg::fcs_op_prog))
    |=> cyc_ff.wr && cyc_ff.addr == addr_ff && cyc_ff.data == wd_ff)
    else $error("program data cycle wrong");
  settle_wait_a: assert property (@(posedge core_clk) disable iff (rst)
    (sq_ff == sq_cmd && cyc_done && ctrl_ff[1:0] != 2'(fcs_pkg::fcs_op_prog))
    |=> sq_ff == sq_wait [*8])
    else $error("settle wait cut short");
  irq_level_a: assert property (@(posedge core_clk) disable iff (rst)
    (irq == $past(irq_exp)) || $past(wr_fire))
    else $error("irq does not follow masked status");
  c_prog: cover property (@(posedge core_clk) disable iff (rst)
    sq_ff == sq_poll ##[1:300] sq_ff == sq_idle);
  c_ident: cover property (@(posedge core_clk) disable iff (rst)
    sq_ff == sq_cmd && ctrl_ff[1:0] == 2'(fcs_pkg::fcs_op_ident));
  c_err: cover property (@(posedge core_clk) disable iff (rst) ev_set[`FCS_IRQ_ERR]);
endmodule

// [tb/fcs_flash_model.sv]
// behavioural flash device on the far side of the host controller
`timescale 1ns/1ps
module fcs_flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h00c3, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h00a6, // arbitrary value
  parameter logic [6:0] PROT_BLOCK = 7'h05,
  parameter logic [6:0] ERASE_BLOCK = 7'h07,
  parameter int BUSY_READS = 3
) (
  input wire logic word_mode,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic [19:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  output logic [15:0] flash_dq_in
);
  logic [15:0] mem [1024]; // low ten lines only, enough for the bench
  logic esusp = 1'b0; // erase held in suspend, set by the bench
  logic etog = 1'b1;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  logic [19:0] wa = 20'h00000;
  logic [15:0] rv;
  logic [15:0] pdata = 16'h0000;
  logic [1:0] step = 2'd0;
  logic ident = 1'b0;
  logic err = 1'b0;
  logic tog = 1'b0;
  int busy = 0;
  wire wr_n = flash_ce_n | flash_we_n;
  wire rd_n = flash_ce_n | flash_oe_n;
  wire [15:0] a1 = word_mode ? 16'h5555 : 16'haaaa;
  wire [15:0] a2 = word_mode ? 16'h2aaa : 16'h5555;
  wire [7:0] cd = flash_dq_out[7:0];
  // address taken at the later of the two falling strobes
  always @(negedge wr_n) wa = flash_addr;
  // command decode at the rising strobe; unlock and command checks use only the low sixteen lines
  always @(posedge wr_n) begin
    if (cd == 8'hf0) begin
      step = 2'd0;
      ident = 1'b0;
      err = 1'b0;
      busy = 0;
    end else if (busy == 0) begin
      case (step)
        2'd0: step = (cd == 8'haa && wa[15:0] == a1) ? 2'd1 : 2'd0;
        2'd1: step = (cd == 8'h55 && wa[15:0] == a2) ? 2'd2 : 2'd0;
        2'd2: begin
          step = 2'd0;
          if (wa[15:0] == a1 && cd == 8'h90) ident = 1'b1;
          else if (wa[15:0] == a1 && cd == 8'ha0) step = 2'd3;
          else ident = 1'b0;
        end
        default: begin
          step = 2'd0;
          // while suspended, the block under erase refuses programs
          if (!esusp || wa[18:12] != ERASE_BLOCK) begin
            pdata = flash_dq_out;
            err = |(flash_dq_out & ~mem[wa[9:0]]);
            mem[wa[9:0]] = mem[wa[9:0]] & flash_dq_out;
            busy = BUSY_READS;
          end
        end
      endcase
    end
  end
  // read value: status while busy, codes in identify mode, else array
  always @* begin
    if (busy != 0) rv = {8'h00, ~pdata[7], tog, err, 2'h0, esusp ? etog : 1'b1, 2'h0};
    else if (ident) begin
      case (flash_addr[1:0])
        2'd0: rv = MAKER_CODE;
        2'd1: rv = DEV_CODE;
        2'd2: rv = {15'h0000, flash_addr[18:12] == PROT_BLOCK};
        default: rv = 16'h0000;
      endcase
    end else rv = mem[flash_addr[9:0]];
  end
  // released bus shows the inverse so a stale sample cannot pass
  assign flash_dq_in = rd_n ? ~rv : rv;
  // a failed program keeps toggling until read/reset
  always @(posedge rd_n) begin
    if (busy != 0) begin
      tog = ~tog;
      if (esusp) etog = ~etog;
      if (!err) busy = busy - 1;
    end
  end
endmodule

// [tb/fcs_host_tb.sv]
// self-checking bench for the flash command sequencer host
`timescale 1ns/1ps
`include "fcs_consts.svh"
module fcs_host_tb;
  logic core_clk, rst, awvalid, wvalid, bready, arvalid, rready, word_mode;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rr, wr_resp;
  logic ce_n, we_n, oe_n, dq_oe;
  logic [19:0] faddr;
  logic [15:0] dq_o, dq_i;
  int n_errors = 0;
  int checks = 0;
  int cyc;
  fcs_host fcs_host_i (.core_clk(core_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq(irq), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_addr(faddr),
    .flash_dq_out(dq_o), .flash_dq_oe(dq_oe), .flash_dq_in(dq_i));
  fcs_flash_model fcs_flash_model_i (.word_mode(word_mode), .flash_ce_n(ce_n),
    .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_addr(faddr), .flash_dq_out(dq_o),
    .flash_dq_in(dq_i));
  // ==========================================================
  // checking and bus tasks
  task automatic end_of_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic timed_out(input int n, input string what);
    if (n >= 5000) begin
      check(what, 32'h0, 32'h1);
      end_of_test();
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 5000);
    wr_resp = bresp;
    bready <= 1'b0;
    timed_out(n, "write response");
    @(posedge core_clk); // let an edge pass before the next request
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 5000);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    timed_out(n, "read response");
    @(posedge core_clk); // let an edge pass before the next request
  endtask
  // start an op and wait for the unmasked interrupt
  task automatic start_op(input logic [31:0] ctrl);
    axi_wr(`FCS_REG_CTRL, ctrl);
    cyc = 0;
    while (irq !== 1'b1 && cyc < 5000) begin
      @(posedge core_clk);
      cyc++;
    end
    timed_out(cyc, "op interrupt");
  endtask
  // run an op, return and clear the flags
  task automatic run_op(input logic [31:0] ctrl, output logic [31:0] flags);
    logic [1:0] r;
    start_op(ctrl);
    axi_rd(`FCS_REG_IRQ, flags, r);
    axi_wr(`FCS_REG_IRQ, 32'h3);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    axi_rd(`FCS_REG_STAT, rd, rr);
    check("stat after reset", rd, 32'h0);
    axi_rd(`FCS_REG_IRQ, rd, rr);
    check("irq status after reset", rd, 32'h0);
    axi_rd(8'h1c, rd, rr);
    check("unmapped resp", {30'h0, rr}, 32'h2);
    check("unmapped data", rd, 32'h0);
    axi_wr(8'h1c, 32'h0);
    check("unmapped write resp", {30'h0, wr_resp}, 32'h2);
    check("idle pins", {28'h0, ce_n, we_n, oe_n, dq_oe}, 32'he);
  endtask
  task automatic t_reset;
    axi_wr(`FCS_REG_MASK, 32'h0);
    axi_wr(`FCS_REG_CTRL, 32'h20); // unlocked read/reset
    repeat (300) @(posedge core_clk);
    check("masked irq", {31'h0, irq}, 32'h0);
    axi_rd(`FCS_REG_IRQ, rd, rr);
    check("done flag", rd & 32'h1, 32'h1);
    axi_wr(`FCS_REG_MASK, 32'h3);
    repeat (2) @(posedge core_clk);
    check("unmasked irq", {31'h0, irq}, 32'h1);
    axi_wr(`FCS_REG_IRQ, 32'h3);
    repeat (2) @(posedge core_clk);
    check("cleared irq", {31'h0, irq}, 32'h0);
    run_op(32'h0, rd); // plain read/reset
    check("settle wait", {31'h0, cyc >= `FCS_ERASE_WAIT_CYC}, 32'h1);
    check("model left commands", {29'h0, fcs_flash_model_i.step, fcs_flash_model_i.ident}, 32'h0);
  endtask
  task automatic t_program;
    axi_wr(`FCS_REG_ADDR, 32'h00123);
    axi_wr(`FCS_REG_WDATA, 32'h00a5);
    run_op(32'h2, rd);
    check("program done", rd & 32'h3, 32'h1);
    check("array after program", fcs_flash_model_i.mem[20'h00123], 32'h00a5);
    run_op(32'h3, rd);
    axi_rd(`FCS_REG_RDATA, rd, rr);
    check("array read back", rd & 32'hffff, 32'h00a5);
  endtask
  task automatic t_prog_err;
    axi_wr(`FCS_REG_WDATA, 32'h00ff);
    start_op(32'h2);
    // status is read before the sticky flags are cleared
    axi_rd(`FCS_REG_STAT, rd, rr);
    check("stat error", rd & 32'h2, 32'h2);
    axi_rd(`FCS_REG_IRQ, rd, rr);
    check("error flag", rd & 32'h3, 32'h2);
    axi_wr(`FCS_REG_IRQ, 32'h3);
    run_op(32'h0, rd);
    check("error cleared", {31'h0, fcs_flash_model_i.err}, 32'h0);
    check("no zero to one", fcs_flash_model_i.mem[20'h00123], 32'h00a5);
  endtask
  task automatic t_ident;
    logic [19:0] ad [4];
    logic [15:0] ex [4];
    ad = '{20'h00000, 20'h00001, 20'h05002, 20'h06002};
    ex = '{16'h00c3, 16'h00a6, 16'h0001, 16'h0000};
    word_mode <= 1'b1;
    run_op(32'h11, rd); // identify in word mode
    for (int i = 0; i < 4; i++) begin
      axi_wr(`FCS_REG_ADDR, {12'h000, ad[i]});
      run_op(32'h13, rd);
      axi_rd(`FCS_REG_RDATA, rd, rr);
      check("identify read", rd & 32'hffff, {16'h0, ex[i]});
    end
    run_op(32'h10, rd);
    axi_wr(`FCS_REG_ADDR, 32'h00200);
    axi_wr(`FCS_REG_WDATA, 32'h1234);
    run_op(32'h12, rd);
    check("word program", fcs_flash_model_i.mem[20'h00200], 32'h1234);
  endtask
  task automatic t_suspend;
    fcs_flash_model_i.esusp = 1'b1;
    axi_wr(`FCS_REG_ADDR, 32'h00124);
    axi_wr(`FCS_REG_WDATA, 32'h005a);
    run_op(32'h12, rd);
    check("suspend program", fcs_flash_model_i.mem[20'h00124], 32'h005a);
    check("erase toggle moved", {31'h0, fcs_flash_model_i.etog}, 32'h0);
    fcs_flash_model_i.esusp = 1'b0;
  endtask
  // ==========================================================
  // clock, reset and main sequence
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    rst = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    {awvalid, wvalid, bready, arvalid, rready, word_mode} = 6'h00;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_reset();
    t_program();
    t_prog_err();
    t_ident();
    t_suspend();
    end_of_test();
  end
endmodule
